// file: pkg/tic_pkg.sv
// Constants for the trap and interrupt controller.
// Assumes an APB master on a 20 MHz pclk and a core that follows take/return strobes.
package tic_pkg;

  // ---------------------------------------------
  // Sizes
  // ---------------------------------------------
  localparam int NSRC     = 16;
  localparam int NEXT     = 3;
  localparam int STK_AW   = 3;
  localparam int CTX_W    = 28;
  localparam int SHD_W    = 69;

  // ---------------------------------------------
  // Register offsets
  // ---------------------------------------------
  localparam logic [7:0] OFF_TRAP = 8'h00;
  localparam logic [7:0] OFF_CTL2 = 8'h04;
  localparam logic [7:0] OFF_FLAG = 8'h08;
  localparam logic [7:0] OFF_ENA  = 8'h0c;
  localparam logic [7:0] OFF_PLO  = 8'h10;
  localparam logic [7:0] OFF_PHI  = 8'h14;
  localparam logic [7:0] OFF_SLIM = 8'h18;
  localparam logic [7:0] OFF_RST  = 8'h1c;

  // ---------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------
  localparam int BIT_ALT      = 15;
  localparam int BIT_CONFLICT = 15;
  localparam int POS_PEND     = 4;
  localparam logic [31:0] RST_PRIO = 32'h44444444;
  localparam logic [15:0] RST_SLIM = 16'hffff;
  localparam logic [15:0] SP_FLOOR = 16'h0800;

  // ---------------------------------------------
  // Trap levels and vectors
  // ---------------------------------------------
  localparam logic [3:0] LVL_MATH  = 4'hb;
  localparam logic [3:0] LVL_ADDR  = 4'hc;
  localparam logic [3:0] LVL_STACK = 4'hd;
  localparam logic [3:0] LVL_OSC   = 4'he;
  localparam logic [5:0] VEC_TRAP0 = 6'h03;
  localparam logic [5:0] VEC_IRQ0  = 6'h08;

endpackage : tic_pkg

// file: src/tic_ctrl.sv
// Trap detection, interrupt arbitration and context stacking with an APB register file.
// Assumes trap condition inputs are one-cycle pulses from the core pipeline.
// Overview of operation
// - Divide by zero aborts the divide and raises the math trap.
// - Enabled accumulator overflow past bit 31 without guard bits raises math trap.
// - Enabled overflow past bit 39 with saturation off raises math trap.
// - Shift count beyond the maximum raises the math trap.
// - Misaligned, unimplemented or vector-space accesses raise the address trap.
// - Multiply-accumulate X accesses treat Y space as unimplemented, and the reverse.
// - Branches or PC changes to unimplemented program memory raise the address trap.
// - Stack pointer loaded above the stack limit raises the stack trap.
// - Stack pointer loaded below 0x0800 raises the stack trap.
// - Oscillator failure onto the RC backup raises the oscillator trap.
// - Soft traps use levels 8 to 11; math sits at 11; fixed priority.
// - Address trap level 12, stack 13, oscillator 14.
// - Any hard trap halts the core until it has been taken.
// - Lower hard trap during a higher one resets and sets the conflict bit.
// - Flags sample events each instruction cycle; flag and enable give a request.
// - A request interrupts only above the current CPU priority level.
// - Taking pushes PC and old priority, then loads the new priority.
// - The trap level bit is clear for interrupts, set only in traps.
// - Return from interrupt pops PC and priority.
// - Alternate vector select routes every vector to the alternate table.
// - One-level shadow of status bits and working registers zero to three, save and restore only.
// - External lines request on edges only; three polarity bits.
// - Priority seven outside traps blocks all interrupts but not traps.
// - Equal priorities resolve by natural order, lowest source number wins.
`timescale 1ns/1ps
module tic_ctrl (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        cyc_start,
  input  wire logic                        div_zero,
  input  wire logic                        acc_a_ovf31,
  input  wire logic                        acc_b_ovf31,
  input  wire logic                        guard_used,
  input  wire logic                        acc_a_ovf39,
  input  wire logic                        acc_b_ovf39,
  input  wire logic                        sat_off,
  input  wire logic                        shift_too_far,
  input  wire logic                        misaligned,
  input  wire logic                        data_unimpl,
  input  wire logic                        prog_data_unimpl,
  input  wire logic                        vec_fetch,
  input  wire logic                        mac_x_access,
  input  wire logic                        mac_y_access,
  input  wire logic                        addr_in_x,
  input  wire logic                        addr_in_y,
  input  wire logic                        branch_unimpl,
  input  wire logic                        pc_unimpl,
  input  wire logic                        sp_load,
  input  wire logic [15:0]                 sp_value,
  input  wire logic                        osc_fail,
  input  wire logic [tic_pkg::NSRC-1:tic_pkg::NEXT] src_event,
  input  wire logic [tic_pkg::NEXT-1:0]    ext_irq_lines,
  input  wire logic [23:0]                 pc_in,
  input  wire logic                        return_from_irq,
  input  wire logic                        shadow_push,
  input  wire logic                        shadow_pop,
  input  wire logic [tic_pkg::SHD_W-1:0]   shadow_in,
  output logic [tic_pkg::SHD_W-1:0]        shadow_out,
  output logic                             take_stb,
  output logic [5:0]                       take_vector,
  output logic                             take_alt,
  output logic                             ret_stb,
  output logic [23:0]                      ret_pc,
  output logic                             halt_core,
  output logic                             conflict_reset,
  output logic [3:0]                       cpu_priority_level
);
  import tic_pkg::*;
  default clocking chk_clk @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ---------------------------------------------
  // State
  // ---------------------------------------------
  logic [2:0]        trap_en;
  logic [3:0]        pend;
  logic              alt_vector_select;
  logic [NEXT-1:0]   ext_irq_edge_polarity_bits;
  logic [NSRC-1:0]   irq_flag_regs;
  logic [NSRC-1:0]   irq_enable_regs;
  logic [NSRC-1:0]   ev_hold;
  logic [63:0]       prio_reg;
  logic [15:0]       stack_limit_reg;
  logic              trap_conflict_reset_flag;
  logic [NEXT-1:0]   ext_prev;
  logic [CTX_W-1:0]  ctx_stk [2**STK_AW];
  logic [STK_AW-1:0] ctx_sp;

  // ---------------------------------------------
  // Trap sources
  // ---------------------------------------------
  wire ovf31 = (trap_en[0] & acc_a_ovf31 | trap_en[1] & acc_b_ovf31)
             & ~guard_used;
  wire ovf39 = trap_en[2] & (acc_a_ovf39 | acc_b_ovf39) & sat_off;
  wire math_ev  = div_zero
                | ovf31 | ovf39
                | shift_too_far;
  wire mac_bad  = mac_x_access & addr_in_y
                | mac_y_access & addr_in_x;
  wire addr_ev  = misaligned | data_unimpl | prog_data_unimpl
                | vec_fetch | mac_bad
                | branch_unimpl | pc_unimpl;
  wire sp_over  = sp_value > stack_limit_reg;
  wire sp_under = sp_value < SP_FLOOR;
  wire stack_ev = sp_load & (sp_over | sp_under);
  wire osc_ev   = osc_fail;
  wire [3:0] trap_ev = {osc_ev, stack_ev, addr_ev, math_ev};

  // ---------------------------------------------
  // Hard trap conflict
  // ---------------------------------------------
  wire [3:0] hard_pend_lvl = pend[3] ? LVL_OSC :
                             pend[2] ? LVL_STACK :
                             pend[1] ? LVL_ADDR : 4'h0;
  wire [3:0] cur_hard = (cpu_priority_level > hard_pend_lvl) ?
                        cpu_priority_level : hard_pend_lvl;
  wire conflict = addr_ev  & (cur_hard > LVL_ADDR)
                | stack_ev & (cur_hard > LVL_STACK)
                | osc_ev   & (cur_hard > LVL_OSC);

  // ---------------------------------------------
  // Trap arbitration
  // ---------------------------------------------
  wire [3:0] trap_lvl = pend[3] ? LVL_OSC :
                        pend[2] ? LVL_STACK :
                        pend[1] ? LVL_ADDR :
                        pend[0] ? LVL_MATH : 4'h0;
  wire [3:0] trap_clr = pend[3] ? 4'h8 :
                        pend[2] ? 4'h4 :
                        pend[1] ? 4'h2 : 4'h1;
  wire [5:0] trap_vec = VEC_TRAP0 + {2'h0, trap_lvl - LVL_MATH};

  // ---------------------------------------------
  // External edges and sources
  // ---------------------------------------------
  wire [NEXT-1:0] ext_edge;
  genvar g;
  generate
    for (g = 0; g < NEXT; g++) begin : g_edge
      assign ext_edge[g] = ext_irq_edge_polarity_bits[g] ?
                           (ext_prev[g] & ~ext_irq_lines[g]) :
                           (~ext_prev[g] & ext_irq_lines[g]);
    end
  endgenerate
  wire [NSRC-1:0] src_now = {src_event, ext_edge};

  // ---------------------------------------------
  // Interrupt arbitration
  // ---------------------------------------------
  wire [2:0] prio [NSRC];
  generate
    for (g = 0; g < NSRC; g++) begin : g_prio
      assign prio[g] = prio_reg[g*4 +: 3];
    end
  endgenerate
  wire [NSRC-1:0] pending = irq_flag_regs & irq_enable_regs;

  logic [2:0] best_prio;
  logic [3:0] best_src;
  logic       best_any;
  always_comb begin
    best_prio = 3'h0;
    best_src  = 4'h0;
    best_any  = 1'b0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pending[i] && (!best_any || prio[i] >= best_prio)) begin
        best_any  = 1'b1;
        best_prio = prio[i];
        best_src  = 4'(i);
      end
    end
  end

  wire trap_go = (|pend) & (trap_lvl > cpu_priority_level);
  wire irq_go  = ~trap_go & best_any
               & ({1'b0, best_prio} > cpu_priority_level);
  wire do_ret  = return_from_irq & (ctx_sp != '0) & ~conflict;
  wire take    = (trap_go | irq_go) & ~take_stb & ~do_ret & ~conflict;
  wire [3:0] take_lvl = trap_go ? trap_lvl : {1'b0, best_prio};
  wire [5:0] next_vec = trap_go ? trap_vec :
                        VEC_IRQ0 + {2'h0, best_src};
  wire [STK_AW-1:0] pop_idx = ctx_sp - 1'b1;

  // ---------------------------------------------
  // APB decode
  // ---------------------------------------------
  wire setup  = psel & ~penable;
  wire wr     = psel & penable & pwrite & pready & ~pslverr;
  wire hit    = paddr[7:5] == 3'h0 && paddr[1:0] == 2'h0;
  wire wr_trap = wr & (paddr == OFF_TRAP);
  wire wr_ctl2 = wr & (paddr == OFF_CTL2);
  wire wr_flag = wr & (paddr == OFF_FLAG);
  wire wr_ena  = wr & (paddr == OFF_ENA);
  wire wr_plo  = wr & (paddr == OFF_PLO);
  wire wr_phi  = wr & (paddr == OFF_PHI);
  wire wr_slim = wr & (paddr == OFF_SLIM);
  wire wr_rst  = wr & (paddr == OFF_RST);
  wire [31:0] rd_mux =
    (paddr == OFF_TRAP) ? {24'h0, pend, 1'b0, trap_en} :
    (paddr == OFF_CTL2) ? {16'h0, alt_vector_select, 12'h0,
                           ext_irq_edge_polarity_bits} :
    (paddr == OFF_FLAG) ? {16'h0, irq_flag_regs} :
    (paddr == OFF_ENA)  ? {16'h0, irq_enable_regs} :
    (paddr == OFF_PLO)  ? prio_reg[31:0] :
    (paddr == OFF_PHI)  ? prio_reg[63:32] :
    (paddr == OFF_SLIM) ? {16'h0, stack_limit_reg} :
    (paddr == OFF_RST)  ? {16'h0, trap_conflict_reset_flag, 11'h0,
                           cpu_priority_level} : 32'h0;

  // ---------------------------------------------
  // Next values
  // ---------------------------------------------
  wire [NSRC-1:0] flag_clr = wr_flag ? pwdata[NSRC-1:0] : '0;
  wire [NSRC-1:0] next_irq_flags = (irq_flag_regs & ~flag_clr)
                  | (cyc_start ? (ev_hold | src_now) : '0);
  wire [NSRC-1:0] next_ev_hold = cyc_start ? '0 : (ev_hold | src_now);
  wire [3:0] next_pend = conflict ? 4'h0 :
                         (pend & ~(take & trap_go ? trap_clr : 4'h0))
                         | trap_ev;
  wire next_conflict_flag = conflict |
       (trap_conflict_reset_flag & ~(wr_rst & pwdata[BIT_CONFLICT]));

  // ---------------------------------------------
  // APB slave
  // ---------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= setup;
      pslverr <= setup & ~hit;
      prdata  <= setup ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trap_en           <= 3'h0;
      alt_vector_select <= 1'b0;
      ext_irq_edge_polarity_bits <= '0;
      irq_enable_regs   <= '0;
      prio_reg          <= {RST_PRIO, RST_PRIO};
      stack_limit_reg   <= RST_SLIM;
    end else begin
      if (wr_trap) trap_en <= pwdata[2:0];
      if (wr_ctl2) begin
        alt_vector_select          <= pwdata[BIT_ALT];
        ext_irq_edge_polarity_bits <= pwdata[NEXT-1:0];
      end
      if (wr_ena)  irq_enable_regs <= pwdata[NSRC-1:0];
      if (wr_plo)  prio_reg[31:0]  <= pwdata;
      if (wr_phi)  prio_reg[63:32] <= pwdata;
      if (wr_slim) stack_limit_reg <= pwdata[15:0];
    end
  end

  // ---------------------------------------------
  // Flags, pending traps and edges
  // ---------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flag_regs            <= '0;
      ev_hold                  <= '0;
      ext_prev                 <= '0;
      pend                     <= 4'h0;
      trap_conflict_reset_flag <= 1'b0;
      halt_core                <= 1'b0;
      conflict_reset           <= 1'b0;
    end else begin
      irq_flag_regs            <= next_irq_flags;
      ev_hold                  <= next_ev_hold;
      ext_prev                 <= ext_irq_lines;
      pend                     <= next_pend;
      trap_conflict_reset_flag <= next_conflict_flag;
      halt_core                <= |next_pend[3:1];
      conflict_reset           <= conflict;
    end
  end

  // ---------------------------------------------
  // Take, return and context stack
  // ---------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_priority_level <= 4'h0;
      ctx_sp             <= '0;
      take_stb           <= 1'b0;
      take_vector        <= 6'h0;
      take_alt           <= 1'b0;
      ret_stb            <= 1'b0;
      ret_pc             <= 24'h0;
    end else begin
      take_stb <= take;
      ret_stb  <= do_ret;
      if (conflict) begin
        cpu_priority_level <= 4'h0;
        ctx_sp             <= '0;
      end else if (take) begin
        ctx_sp             <= ctx_sp + 1'b1;
        cpu_priority_level <= take_lvl;
        take_vector        <= next_vec;
        take_alt           <= alt_vector_select;
      end else if (do_ret) begin
        ctx_sp             <= pop_idx;
        cpu_priority_level <= ctx_stk[pop_idx][3:0];
        ret_pc             <= ctx_stk[pop_idx][CTX_W-1:4];
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (take && !conflict) ctx_stk[ctx_sp] <= {pc_in, cpu_priority_level};
  end

  // ---------------------------------------------
  // Shadow registers
  // ---------------------------------------------
  logic [SHD_W-1:0] shadow_copy;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shadow_copy <= '0;
      shadow_out  <= '0;
    end else begin
      if (shadow_push) shadow_copy <= shadow_in;
      if (shadow_pop)  shadow_out  <= shadow_copy;
    end
  end

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  property p_div_zero;
    div_zero && !conflict |=> pend[0];
  endproperty
  a_div_zero: assert property (p_div_zero) else $error("div0 no math trap");
  property p_ovf39;
    trap_en[2] && acc_b_ovf39 && sat_off && !conflict |=> pend[0];
  endproperty
  a_ovf39: assert property (p_ovf39) else $error("bit39 overflow missed");
  property p_stack_under;
    sp_load && sp_value < 16'h0800 |=> pend[2] || conflict_reset;
  endproperty
  a_stack_under: assert property (p_stack_under) else $error("underflow missed");
  property p_halt;
    (addr_ev || stack_ev) && !conflict |=> halt_core;
  endproperty
  a_halt: assert property (p_halt) else $error("hard trap without halt");
  property p_conflict;
    pend[3:2] != 2'h0 && addr_ev |=> conflict_reset && trap_conflict_reset_flag
                                     && cpu_priority_level == 4'h0;
  endproperty
  a_conflict: assert property (p_conflict) else $error("conflict not reset");
  property p_take_level;
    take |=> take_stb && cpu_priority_level > $past(cpu_priority_level);
  endproperty
  a_take_level: assert property (p_take_level) else $error("priority not raised");
  property p_irq_bit;
    take_stb && take_vector >= 6'h08 |-> !cpu_priority_level[3];
  endproperty
  a_irq_bit: assert property (p_irq_bit) else $error("trap bit set in irq");
  property p_trap_bit;
    take_stb && take_vector < 6'h08 |-> cpu_priority_level[3];
  endproperty
  a_trap_bit: assert property (p_trap_bit) else $error("trap bit clear in trap");
  property p_ipl7;
    cpu_priority_level == 4'h7 && pend == 4'h0 |=> !take_stb;
  endproperty
  a_ipl7: assert property (p_ipl7) else $error("irq taken at level 7");
  property p_return;
    do_ret |=> ret_stb && cpu_priority_level < $past(cpu_priority_level)
               && (ctx_sp != '0 || cpu_priority_level == 4'h0);
  endproperty
  a_return: assert property (p_return) else $error("return lost priority");
  property p_alt;
    take |=> take_alt == $past(alt_vector_select);
  endproperty
  a_alt: assert property (p_alt) else $error("wrong vector table");
  property p_edge;
    !ext_irq_edge_polarity_bits[0] && !ext_prev[0] && ext_irq_lines[0] && !cyc_start
    |=> ev_hold[0];
  endproperty
  a_edge: assert property (p_edge) else $error("rising edge missed");
endmodule : tic_ctrl

// file: verification/tic_core_model.sv
// Core-side model: instruction-cycle strobe, running PC and delayed return from service.
// Assumes take_stb is a one-cycle pulse; returns one level per ret_delay plus one cycles.
`timescale 1ns/1ps
module tic_core_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        take_stb,
  input  wire logic [7:0]  ret_delay,
  output logic             cyc_start,
  output logic             return_from_irq,
  output logic [23:0]      pc_in
);
  logic [1:0] phase;
  logic [7:0] wait_cnt;
  logic [3:0] depth;
  // ---------------------------------------------
  // Instruction cycles and nested service depth
  // ---------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase           <= 2'h0;
      wait_cnt        <= 8'h00;
      depth           <= 4'h0;
      cyc_start       <= 1'b0;
      return_from_irq <= 1'b0;
      pc_in           <= 24'h000100;
    end else begin
      phase           <= phase + 2'h1;
      cyc_start       <= (phase == 2'h3);
      pc_in           <= cyc_start ? pc_in + 24'h000002 : pc_in;
      return_from_irq <= !take_stb && depth != 4'h0 && wait_cnt == 8'h00;
      if (take_stb) begin
        depth    <= depth + 4'h1;
        wait_cnt <= ret_delay;
      end else if (depth != 4'h0 && wait_cnt == 8'h00) begin
        depth    <= depth - 4'h1;
        wait_cnt <= ret_delay;
      end else if (wait_cnt != 8'h00) begin
        wait_cnt <= wait_cnt - 8'h01;
      end
    end
  end
endmodule : tic_core_model

// file: verification/tic_ctrl_tb_top.sv
// Bench for the trap and interrupt controller: APB master, trap pulses, events, edges.
// Assumes the core model strobes instruction cycles and returns from each take.
`timescale 1ns/1ps
module tic_ctrl_tb_top;
  import tic_pkg::*;
  logic             pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]       paddr = 8'h00, ret_delay = 8'h14;
  logic [31:0]      pwdata = 32'h0, prdata, rd;
  logic             pready, pslverr, err, cyc_start, return_from_irq, take_stb, take_alt, ret_stb;
  logic             halt_core, conflict_reset, seen_halt, seen_conf, lax = 1'b0;
  logic             sp_load = 1'b0, shadow_push = 1'b0, shadow_pop = 1'b0;
  logic [14:0]      tp = 15'h0;
  logic [3:0]       lv = 4'h4, cpu_priority_level;
  logic [NSRC-1:NEXT] src_event = 13'h0;
  logic [NEXT-1:0]  ext_irq_lines = 3'h0;
  logic [15:0]      sp_value = 16'h0;
  logic [SHD_W-1:0] shadow_in = 69'h0, shadow_out, sh;
  logic [5:0]       take_vector;
  logic [23:0]      ret_pc, pc_in, pc_last = 24'h0, pcq[$];
  logic [10:0]      e, expq[$];
  int               n_fail = 0, total_checks = 0, seed = 68, s, b, k;
  always #25 pclk = ~pclk;
  tic_ctrl i_tic_ctrl (.*, .div_zero(tp[0]), .acc_a_ovf31(tp[1]), .acc_b_ovf31(tp[2]),
    .acc_a_ovf39(tp[3]), .acc_b_ovf39(tp[4]), .shift_too_far(tp[5]), .misaligned(tp[6]),
    .data_unimpl(tp[7]), .prog_data_unimpl(tp[8]), .vec_fetch(tp[9]), .branch_unimpl(tp[10]),
    .pc_unimpl(tp[11]), .osc_fail(tp[12]), .mac_x_access(tp[13]), .mac_y_access(tp[14]),
    .guard_used(lv[3]), .sat_off(lv[2]), .addr_in_x(lv[1]), .addr_in_y(lv[0]));
  tic_core_model i_tic_core_model (.*);
  // ---------------------------------------------
  // Checking and closing
  // ---------------------------------------------
  task automatic chk(input string w, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", w, x, g);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  task automatic tmo(input string w);
    n_fail++;
    $display("ERROR timeout %s expected done seen hung", w);
    complete_run();
  endtask : tmo
  always @(posedge pclk) begin
    if (halt_core === 1'b1) seen_halt = 1'b1;
    if (conflict_reset === 1'b1) seen_conf = 1'b1;
    if (ret_stb === 1'b1) begin
      if (pcq.size() == 0) chk("ret_unexpected", 32'h0, 32'h1);
      else chk("ret_pc", {8'h0, pcq.pop_back()}, {8'h0, ret_pc});
    end
    if (take_stb === 1'b1) pcq.push_back(pc_last);
    pc_last = pc_in;
    if (take_stb === 1'b1 && !lax) begin
      if (expq.size() == 0) chk("take_unexpected", 32'h0, 32'h1);
      else begin
        e = expq.pop_front();
        chk("take", {21'h0, e}, {21'h0, take_alt, take_vector, cpu_priority_level});
      end
    end
  end
  // ---------------------------------------------
  // Drivers
  // ---------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) tmo("apb");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    chk("prdata", x, rd);
    chk("pslverr", {31'h0, xe}, {31'h0, err});
  endtask : rdchk
  task automatic settle;
    for (k = 0; k < 300 && (expq.size() != 0 || cpu_priority_level !== 4'h0); k++) @(posedge pclk);
    if (expq.size() != 0 || cpu_priority_level !== 4'h0) tmo("settle");
    repeat (4) @(posedge pclk);
  endtask : settle
  task automatic pulse(input logic [14:0] m);
    @(posedge pclk);
    seen_halt = 1'b0;
    tp <= m;
    @(posedge pclk);
    tp <= 15'h0;
    settle();
  endtask : pulse
  task automatic spl(input logic [15:0] v, input logic t);
    if (t) expq.push_back({1'b0, VEC_TRAP0 + 6'h2, LVL_STACK});
    @(posedge pclk);
    sp_load <= 1'b1;
    sp_value <= v;
    @(posedge pclk);
    sp_load <= 1'b0;
    settle();
  endtask : spl
  task automatic fire(input logic [15:0] m);
    @(posedge pclk);
    src_event <= m[15:3];
    @(posedge pclk);
    src_event <= 13'h0;
  endtask : fire
  task automatic serve(input int q, input int n);
    for (k = 0; k < 300 && expq.size() > n; k++) @(posedge pclk);
    if (expq.size() > n) tmo("serve");
    apb(1'b1, OFF_FLAG, 32'h1 << q);
  endtask : serve
  task automatic edge_to(input logic [2:0] v);
    @(posedge pclk);
    ext_irq_lines <= v;
  endtask : edge_to
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  initial begin
    repeat (90000) @(posedge pclk);
    tmo("run");
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(OFF_SLIM, 32'h0000ffff, 1'b0);
    rdchk(OFF_PLO, RST_PRIO, 1'b0);
    rdchk(8'h20, 32'h0, 1'b1);
    rdchk(8'h06, 32'h0, 1'b1);
    apb(1'b1, OFF_TRAP, 32'h7);
    for (b = 0; b < 15; b++) begin
      lv <= (b == 14) ? 4'h6 : 4'h5;
      expq.push_back(b < 6 ? {1'b0, VEC_TRAP0, LVL_MATH} : b == 12 ?
        {1'b0, VEC_TRAP0 + 6'h3, LVL_OSC} : {1'b0, VEC_TRAP0 + 6'h1, LVL_ADDR});
      pulse(15'h1 << b);
      chk("halt", {31'h0, b >= 6}, {31'h0, seen_halt});
    end
    lv <= 4'h8;
    pulse(15'h001e);
    lv <= 4'h5;
    expq.push_back({1'b0, VEC_TRAP0 + 6'h1, LVL_ADDR});
    expq.push_back({1'b0, VEC_TRAP0, LVL_MATH});
    pulse(15'h0041);
    apb(1'b1, OFF_SLIM, 32'h1000);
    spl(16'h1001, 1'b1);
    spl(16'h1000, 1'b0);
    spl(16'h07ff, 1'b1);
    spl(16'h0800, 1'b0);
    apb(1'b1, OFF_CTL2, 32'h8000);
    expq.push_back({1'b1, VEC_TRAP0, LVL_MATH});
    pulse(15'h0001);
    apb(1'b1, OFF_CTL2, 32'h0);
    sh = 69'({$random(seed), $random(seed), $random(seed)});
    @(posedge pclk);
    shadow_in <= sh;
    shadow_push <= 1'b1;
    @(posedge pclk);
    shadow_push <= 1'b0;
    shadow_in <= ~sh;
    shadow_pop <= 1'b1;
    @(posedge pclk);
    shadow_pop <= 1'b0;
    @(posedge pclk);
    chk("shadow", 32'h1, {31'h0, shadow_out === sh});
    s = 3 + ($unsigned($random(seed)) % 13);
    apb(1'b1, OFF_ENA, 32'h1 << s);
    expq.push_back({1'b0, VEC_IRQ0 + 6'(s), 4'h4});
    fire(16'h1 << s);
    serve(s, 0);
    settle();
    apb(1'b1, OFF_ENA, 32'h220);
    expq.push_back({1'b0, VEC_IRQ0 + 6'h5, 4'h4});
    expq.push_back({1'b0, VEC_IRQ0 + 6'h9, 4'h4});
    fire(16'h0220);
    serve(5, 1);
    serve(9, 0);
    settle();
    apb(1'b1, OFF_PHI, 32'h44444474);
    expq.push_back({1'b0, VEC_IRQ0 + 6'h9, 4'h7});
    expq.push_back({1'b0, VEC_IRQ0 + 6'h5, 4'h4});
    fire(16'h0220);
    serve(9, 1);
    serve(5, 0);
    settle();
    apb(1'b1, OFF_CTL2, 32'h2);
    edge_to(3'h2);
    apb(1'b1, OFF_ENA, 32'h3);
    expq.push_back({1'b0, VEC_IRQ0, 4'h4});
    edge_to(3'h3);
    serve(0, 0);
    settle();
    expq.push_back({1'b0, VEC_IRQ0 + 6'h1, 4'h4});
    edge_to(3'h1);
    serve(1, 0);
    settle();
    edge_to(3'h0);
    repeat (8) @(posedge pclk);
    rdchk(OFF_FLAG, 32'h0, 1'b0);
    lax = 1'b1;
    seen_conf = 1'b0;
    @(posedge pclk);
    tp <= 15'h1000;
    @(posedge pclk);
    tp <= 15'h0040;
    @(posedge pclk);
    tp <= 15'h0;
    repeat (10) @(posedge pclk);
    chk("conflict", 32'h1, {31'h0, seen_conf});
    rdchk(OFF_RST, 32'h00008000, 1'b0);
    complete_run();
  end
endmodule : tic_ctrl_tb_top
